// >>> frame_protocol_error_tracker.sv
/*
 * Protocol-level frame error tracker, one small state machine per channel.
 * Assumes all inputs come from decoder and PHY adapter logic clocked by
 * clk_i (the receive byte clock), with single-cycle event pulses.
 */
// Overview of operation
// RULE_01 - frame end without earlier start on same channel raises pairing error
// RULE_02 - start sync loss from PHY adapter raises pairing error
// RULE_03 - payload error shown after frame end if frame payload had errors
// RULE_04 - pairing error reported together with its channel identifier
// RULE_05 - second start without end marks first frame erroneous
// RULE_06 - second end without start marks second end's frame erroneous
// RULE_07 - after header double-bit error discard everything until lane idle
// RULE_08 - after start sync loss discard everything until lane idle
// RULE_09 - payload error set on checksum error, cleared at next frame end
// RULE_10 - one sequential state machine per channel
// RULE_11 - decoder pulses checksum error on payload checksum mismatch
// RULE_12 - PHY adapter pulses sync loss for one cycle on bad leader
// RULE_13 - decoder flags header double-bit error on uncorrectable syndrome
// RULE_14 - reset: no frame open, errors low, discard cleared
// RULE_15 - while discarding ignore start/end; leave only on lane idle
`timescale 1ns/1ns
module frame_protocol_error_tracker
   import frame_error_pkg::*;
(
   input  wire logic                               clk_i,                  // receive byte clock
   input  wire logic                               arst_n_i,               // async reset, low
   input  wire logic                               frame_begin_packet_i,   // start short packet
   input  wire logic                               frame_finish_packet_i,  // end short packet
   input  wire logic [frame_error_pkg::VC_WIDTH-1:0] packet_vc_i,          // packet channel
   input  wire logic                               payload_valid_i,        // payload byte valid
   input  wire logic                               payload_checksum_error_i, // checksum pulse
   input  wire logic                               header_double_bit_error_i, // header pulse
   input  wire logic                               start_sync_loss_error_i,  // sync loss pulse
   input  wire logic                               lane_idle_indication_i, // lane stop state
   output logic                                    frame_pairing_error_o,  // pairing error pulse
   output logic [frame_error_pkg::VC_WIDTH-1:0]    frame_pairing_vc_o,     // channel of error
   output logic [frame_error_pkg::VC_COUNT-1:0]    frame_payload_error_o,  // per channel level
   output logic                                    data_valid_o,           // payload qualified
   output logic                                    discard_active_o        // discarding content
);
   import frame_error_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      frame_state_type [VC_COUNT-1:0] fstate;
      logic [VC_COUNT-1:0]            bad_frame;    // checksum seen in open frame
      logic [VC_COUNT-1:0]            payload_err;
      logic                           pair_err;
      logic [VC_WIDTH-1:0]            pair_vc;
      logic                           discard;
      logic                           dvalid;
   } state_type;

   state_type st_r;
   state_type st_nxt;

   // ---------------------------------------------------------------
   // per-channel view
   // ---------------------------------------------------------------
   typedef struct packed {
      frame_state_type fstate;
      logic            bad_frame;
      logic            payload_err;
      logic            pair_err;
   } chan_type;

   chan_type [VC_COUNT-1:0] chan_cur;
   chan_type [VC_COUNT-1:0] chan_nxt;
   logic                    fatal_event;
   logic                    listening;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic vc_hit(input logic [VC_WIDTH-1:0] vc, input int unsigned idx);
      vc_hit = (vc == idx[VC_WIDTH-1:0]);
   endfunction : vc_hit

   // either unrecoverable error starts a discard
   function automatic logic is_fatal(input logic hdr_err, input logic sync_err);
      is_fatal = hdr_err || sync_err;
   endfunction : is_fatal

   // entry wins over idle exit in the same cycle
   function automatic logic next_discard(
      input logic cur,
      input logic fatal,
      input logic idle
   );
      if (fatal) begin
         next_discard = 1'b1;
      end else if (idle) begin
         next_discard = 1'b0;
      end else begin
         next_discard = cur;
      end
   endfunction : next_discard

   // one clock of a single channel's pairing machine
   function automatic chan_type chan_step(
      input chan_type c,
      input logic     begin_pkt,
      input logic     finish_pkt,
      input logic     crc_err
   );
      chan_type n;
      n          = c;
      n.pair_err = 1'b0;
      if (crc_err && c.fstate == FRAME_OPEN) begin
         n.bad_frame = 1'b1;                                     // see RULE_09
      end
      case (c.fstate)
         FRAME_CLOSED: begin
            if (begin_pkt) begin
               n.fstate    = FRAME_OPEN;
               n.bad_frame = 1'b0;
            end else if (finish_pkt) begin
               n.pair_err = 1'b1;                                // see RULE_01 see RULE_06
            end
         end
         FRAME_OPEN: begin
            if (begin_pkt) begin
               n.pair_err  = 1'b1;                               // see RULE_05
               n.bad_frame = 1'b0;
            end else if (finish_pkt) begin
               n.fstate      = FRAME_CLOSED;
               n.payload_err = c.bad_frame || crc_err;           // see RULE_03 see RULE_09
               n.bad_frame   = 1'b0;
            end
         end
         default: begin
            n.fstate = FRAME_RESET;
         end
      endcase
      chan_step = n;
   endfunction : chan_step

   // ---------------------------------------------------------------
   // channel machines
   // ---------------------------------------------------------------
   assign fatal_event = is_fatal(header_double_bit_error_i, start_sync_loss_error_i);
   assign listening   = !st_r.discard;

   always_comb begin
      for (int unsigned i = 0; i < VC_COUNT; i++) begin
         chan_cur[i].fstate      = st_r.fstate[i];
         chan_cur[i].bad_frame   = st_r.bad_frame[i];
         chan_cur[i].payload_err = st_r.payload_err[i];
         chan_cur[i].pair_err    = 1'b0;
      end
   end

   always_comb begin
      for (int unsigned i = 0; i < VC_COUNT; i++) begin         // see RULE_10
         if (listening && vc_hit(packet_vc_i, i)) begin         // see RULE_15
            chan_nxt[i] = chan_step(chan_cur[i], frame_begin_packet_i,
                                    frame_finish_packet_i, payload_checksum_error_i);
         end else begin
            chan_nxt[i] = chan_cur[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt          = st_r;
      st_nxt.pair_err = 1'b0;
      st_nxt.discard  = next_discard(st_r.discard, fatal_event,
                                     lane_idle_indication_i);   // see RULE_15
      // no payload qualified once discard starts
      st_nxt.dvalid   = listening && !fatal_event && payload_valid_i; // see RULE_07 see RULE_08
      for (int unsigned i = 0; i < VC_COUNT; i++) begin
         st_nxt.fstate[i]      = chan_nxt[i].fstate;
         st_nxt.bad_frame[i]   = chan_nxt[i].bad_frame;
         st_nxt.payload_err[i] = chan_nxt[i].payload_err;
         if (chan_nxt[i].pair_err) begin
            st_nxt.pair_err = 1'b1;
            st_nxt.pair_vc  = packet_vc_i;                      // see RULE_04
         end
      end
      if (start_sync_loss_error_i) begin
         st_nxt.pair_err = 1'b1;                                // see RULE_02
         st_nxt.pair_vc  = packet_vc_i;                         // see RULE_04
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r.fstate      <= '{default: FRAME_RESET};            // see RULE_14
         st_r.bad_frame   <= {VC_COUNT{BIT_RESET}};
         st_r.payload_err <= {VC_COUNT{BIT_RESET}};
         st_r.pair_err    <= BIT_RESET;
         st_r.pair_vc     <= '0;
         st_r.discard     <= BIT_RESET;
         st_r.dvalid      <= BIT_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign frame_pairing_error_o = st_r.pair_err;
   assign frame_pairing_vc_o    = st_r.pair_vc;
   assign frame_payload_error_o = st_r.payload_err;
   assign data_valid_o          = st_r.dvalid;
   assign discard_active_o      = st_r.discard;

endmodule : frame_protocol_error_tracker

// >>> frame_error_pkg.sv
/*
 * Constants and types shared by the frame protocol error tracker.
 * Assumes a single receive byte clock domain and a 2-bit channel identifier.
 */
package frame_error_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int unsigned VC_WIDTH  = 2;
   localparam int unsigned VC_COUNT  = 4;

   // ---------------------------------------------------------------
   // per-channel pairing states
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      FRAME_CLOSED = 1'b0,
      FRAME_OPEN   = 1'b1
   } frame_state_type;

   localparam frame_state_type FRAME_RESET = FRAME_CLOSED;
   localparam logic            BIT_RESET   = 1'b0;

endpackage : frame_error_pkg

// >>> frame_tracker_checker.sv
/* assertions on the frame error tracker ports; assumes bind at the foot of this file */
`timescale 1ns/1ns
module frame_tracker_checker
   import frame_error_pkg::*;
(
   input wire logic                clk_i, arst_n_i, frame_begin_packet_i, frame_finish_packet_i,
   input wire logic [VC_WIDTH-1:0] packet_vc_i, frame_pairing_vc_o,
   input wire logic                payload_valid_i, payload_checksum_error_i,
   input wire logic                header_double_bit_error_i, start_sync_loss_error_i,
   input wire logic                lane_idle_indication_i, frame_pairing_error_o,
   input wire logic [VC_COUNT-1:0] frame_payload_error_o,
   input wire logic                data_valid_o, discard_active_o
);
   wire new_err = header_double_bit_error_i | start_sync_loss_error_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_sync; !discard_active_o && start_sync_loss_error_i |=> frame_pairing_error_o
      && discard_active_o && frame_pairing_vc_o == $past(packet_vc_i); endproperty
   a_sync: assert property (p_sync) else $error("sync loss not flagged");
   property p_hdr; header_double_bit_error_i |=> discard_active_o ##1 !data_valid_o; endproperty
   a_hdr: assert property (p_hdr) else $error("header error not muting");
   property p_mute; discard_active_o |=> !data_valid_o; endproperty
   a_mute: assert property (p_mute) else $error("data valid while muted");
   property p_hold; discard_active_o && !lane_idle_indication_i |=> discard_active_o; endproperty
   a_hold: assert property (p_hold) else $error("discard left early");
   property p_exit; discard_active_o && lane_idle_indication_i && !new_err
      |=> !discard_active_o; endproperty
   a_exit: assert property (p_exit) else $error("discard kept");
   property p_deaf; discard_active_o && !start_sync_loss_error_i |=> !frame_pairing_error_o;
   endproperty
   a_deaf: assert property (p_deaf) else $error("pairing while muted");
   property p_vc; !frame_pairing_error_o |-> $stable(frame_pairing_vc_o); endproperty
   a_vc: assert property (p_vc) else $error("channel id moved");
   property p_pay; !frame_finish_packet_i |=> $stable(frame_payload_error_o); endproperty
   a_pay: assert property (p_pay) else $error("payload error moved");
   cover property (start_sync_loss_error_i ##1 discard_active_o);
   cover property ($rose(frame_payload_error_o[1]));
   cover property ($fell(discard_active_o));
endmodule : frame_tracker_checker
bind frame_protocol_error_tracker frame_tracker_checker chk (.*);

// >>> link_source.sv
/* decoder and lane adapter model; assumes the bench calls step once per event */
`timescale 1ns/1ns
module link_source (
   input  wire logic       clk_i, // byte clock
   output logic      [8:0] ev_o   // idle,sync,hdr,crc,valid,vc,end,start
);
   initial ev_o = 9'h000;
   task step(input logic [8:0] v);
      @(posedge clk_i);
      ev_o <= v;
      @(posedge clk_i);
      ev_o <= 9'h000;
   endtask : step
endmodule : link_source

// >>> frame_protocol_error_tracker_bench.sv
/* bench for the frame error tracker; assumes link_source and the checker */
`timescale 1ns/1ns
module frame_protocol_error_tracker_bench;
   import frame_error_pkg::*;
   logic       clk_i      = 1'b0;
   logic       arst_n_i   = 1'b0;
   wire  [8:0] ev;
   wire  [8:0] obs;
   int         mismatches = 0;
   int         n_checks   = 0;
   int         cycles     = 0;
   initial forever #25 clk_i = ~clk_i;
   link_source lnk (.clk_i(clk_i), .ev_o(ev));
   frame_protocol_error_tracker dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .frame_begin_packet_i(ev[0]), .frame_finish_packet_i(ev[1]), .packet_vc_i(ev[3:2]),
      .payload_valid_i(ev[4]), .payload_checksum_error_i(ev[5]),
      .header_double_bit_error_i(ev[6]), .start_sync_loss_error_i(ev[7]),
      .lane_idle_indication_i(ev[8]), .frame_pairing_error_o(obs[8]),
      .frame_pairing_vc_o(obs[7:6]), .frame_payload_error_o(obs[5:2]),
      .data_valid_o(obs[1]), .discard_active_o(obs[0]));
   task stop_test;
      if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task check(input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task ev_then(input logic [8:0] v, input logic [8:0] e);
      lnk.step(v);
      #1 check(obs, e);
   endtask : ev_then
   task unpaired;
      ev_then(9'h00E, 9'h1C0);
      ev_then(9'h00D, 9'h0C0);
      ev_then(9'h00E, 9'h0C0);
      ev_then(9'h00E, 9'h1C0);
   endtask : unpaired
   task payload;
      ev_then(9'h005, 9'h0C0);
      ev_then(9'h024, 9'h0C0);
      ev_then(9'h009, 9'h0C0);
      ev_then(9'h009, 9'h180);
      ev_then(9'h006, 9'h088);
      ev_then(9'h00A, 9'h088);
      ev_then(9'h005, 9'h088);
      ev_then(9'h006, 9'h080);
      ev_then(9'h00D, 9'h080);
      ev_then(9'h02E, 9'h0A0);
      ev_then(9'h001, 9'h0A0);
      ev_then(9'h020, 9'h0A0);
      ev_then(9'h002, 9'h0A4);
      ev_then(9'h00D, 9'h0A4);
      ev_then(9'h00E, 9'h084);
      ev_then(9'h001, 9'h084);
      ev_then(9'h002, 9'h080);
   endtask : payload
   task reset_mid;
      ev_then(9'h0C5, 9'h141);
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      @(posedge clk_i);
      #1 check(obs, 9'h000);
      @(posedge clk_i);
      arst_n_i <= 1'b1;
      #1 check(obs, 9'h000);
      ev_then(9'h006, 9'h140);
   endtask : reset_mid
   task discard;
      ev_then(9'h010, 9'h082);
      ev_then(9'h088, 9'h181);
      ev_then(9'h012, 9'h081);
      ev_then(9'h100, 9'h080);
      ev_then(9'h040, 9'h081);
      ev_then(9'h011, 9'h081);
      ev_then(9'h100, 9'h080);
      ev_then(9'h002, 9'h100);
   endtask : discard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 500) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      #1 check(obs, 9'h000);
      unpaired();
      payload();
      discard();
      reset_mid();
      stop_test();
   end
endmodule : frame_protocol_error_tracker_bench
